// >>> logic/ieb_bank.sv
// interrupt enable bank: five 16-bit enable registers behind wishbone
// assumes pending inputs from peripherals on the same clock as clk_i
// Operation
// - an enable bit of one passes its source request, zero blocks it.
// - every implemented enable bit is read/write and clears to zero on reset.
// - unimplemented bit positions always read as zero.
// - register one bits 2,1,0 gate comparator, first i2c master, first i2c slave.
// - register two gates parallel port, output compares 8-5, captures 6-3, spi b.
// - register three gates calendar, external 4 and 3, second i2c master and slave.
// - register four gates charge time, low voltage, checksum, uart b and a errors.
// - register five bits 13-7 gate capture 9, compare 9, spi c, uart d tx/rx/error.
// - register five bits 5-1 gate third i2c master/slave and uart c tx/rx/error.
// - a priority code of zero disables the source, all ones is level seven.
//
// The Wishbone register port and the address map were decided locally.
`timescale 1ns/1ps
module ieb_bank #(
  parameter int N = 80
) (
  // clock and reset
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  // wishbone slave
  input  wire logic          cyc_i,
  input  wire logic          stb_i,
  input  wire logic          we_i,
  input  wire logic [7:0]    adr_i,
  input  wire logic [3:0]    sel_i,
  input  wire logic [31:0]   dat_i,
  output logic      [31:0]   dat_o,
  output logic               ack_o,
  output logic               err_o,
  // sources and core side
  input  wire logic [N-1:0]  pend_i,
  output logic      [N-1:0]  req_o,
  output logic      [2:0]    prio_o,
  output logic               irq_o
);

  // ==========================================================================
  // storage
  logic [15:0] en_reg [ieb_pkg::NUM_EN];
  logic [2:0]  prio;
  logic [4:0]  irq_st;
  logic [4:0]  irq_msk;
  logic [N-1:0] req_q;
  ieb_gate_if #(.N(N)) gif ();

  // ==========================================================================
  // decode
  wire        acc      = cyc_i & stb_i & ~ack_o & ~err_o;
  wire        wr_lo    = acc & we_i & sel_i[0];
  wire        wr_hi    = acc & we_i & sel_i[1];
  wire        hit_en   = (adr_i[1:0] == 2'h0) && (adr_i < ieb_pkg::OFS_PEND);
  wire [2:0]  en_idx   = adr_i[4:2];
  wire        hit_pend = adr_i == ieb_pkg::OFS_PEND;
  wire        hit_st   = adr_i == ieb_pkg::OFS_IRQ_ST;
  wire        hit_msk  = adr_i == ieb_pkg::OFS_IRQ_MSK;
  wire        hit_prio = adr_i == ieb_pkg::OFS_PRIO;
  wire        mapped   = hit_en | hit_pend | hit_st | hit_msk | hit_prio;
  wire        rd_st    = acc & ~we_i & hit_st;

  // ==========================================================================
  // enable registers; unimplemented bits never stored
  genvar r;
  generate
    for (r = 0; r < ieb_pkg::NUM_EN; r++) begin : g_en
      wire [15:0] msk = ieb_pkg::MASK_ALL[16*r +: 16];
      wire        sel = hit_en && (en_idx == 3'(r));
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          en_reg[r] <= ieb_pkg::RST_EN;
        end else begin
          if (sel && wr_lo) en_reg[r][7:0]  <= dat_i[7:0] & msk[7:0];
          if (sel && wr_hi) en_reg[r][15:8] <= dat_i[15:8] & msk[15:8];
        end
      end
      // bit layout per register: see masks in package
      assign gif.en[16*r +: 16] = en_reg[r];
    end
  endgenerate

  // ==========================================================================
  // priority register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prio <= ieb_pkg::RST_PRIO;
    end else if (hit_prio && wr_lo) begin
      prio <= dat_i[2:0];
    end
  end

  // ==========================================================================
  // gate and request registers
  assign gif.pend = pend_i;
  assign gif.prio = prio;
  ieb_gate #(.N(N)) u_gate (.g(gif.gate));

  always_ff @(posedge clk_i) begin
    if (rst_i) req_q <= '0;
    else       req_q <= gif.req;
  end
  assign req_o  = req_q;
  assign prio_o = prio;

  // ==========================================================================
  // summary interrupt: one sticky bit per enable register
  logic [4:0] grp_any;
  generate
    for (r = 0; r < ieb_pkg::NUM_EN; r++) begin : g_grp
      assign grp_any[r] = |gif.req[16*r +: 16];
    end
  endgenerate
  // set beats read-clear
  wire [4:0] next_irq_st = grp_any | (rd_st ? 5'h00 : irq_st);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_st  <= ieb_pkg::RST_IRQ;
      irq_msk <= ieb_pkg::RST_IRQ;
    end else begin
      irq_st <= next_irq_st;
      if (hit_msk && wr_lo) irq_msk <= dat_i[4:0];
    end
  end
  assign irq_o = |(irq_st & irq_msk);

  // ==========================================================================
  // read mux and ack
  wire [15:0] rd_en = (en_idx < 3'(ieb_pkg::NUM_EN)) ? en_reg[en_idx] : 16'h0000;
  wire [31:0] rd_mux =
      hit_en   ? {16'h0000, rd_en} :
      hit_pend ? 32'h00000000 :
      hit_st   ? {27'h0000000, irq_st} :
      hit_msk  ? {27'h0000000, irq_msk} :
      hit_prio ? {29'h00000000, prio} : 32'h00000000;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      err_o <= 1'b0;
      dat_o <= 32'h00000000;
    end else begin
      ack_o <= acc & mapped;
      err_o <= acc & ~mapped;
      dat_o <= (acc & ~we_i) ? rd_mux : 32'h00000000;
    end
  end

  // ==========================================================================
  // checks
  a_req_gated: assert property (@(posedge clk_i) disable iff (rst_i)
    ##1 req_o == $past(pend_i & gif.en & {N{prio != ieb_pkg::PRIO_OFF}}))
    else $error("request not gated by enable");
  a_en_reset: assert property (@(posedge clk_i) $past(rst_i) |-> en_reg[0] == 16'h0000)
    else $error("enable not cleared by reset");
  a_unimpl_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    (en_reg[1] & ~ieb_pkg::MASK_EN2) == 16'h0000)
    else $error("unimplemented bit stored");
  a_write_takes: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_lo && wr_hi && hit_en && en_idx == 3'h4 |=> en_reg[4] == ($past(dat_i[15:0]) & 16'h3FBE))
    else $error("enable write lost");
  a_prio_off: assert property (@(posedge clk_i) disable iff (rst_i)
    prio == 3'h0 |=> req_o == '0)
    else $error("priority zero passed request");
  a_ack_once: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_o |=> !ack_o)
    else $error("ack held two cycles");
  a_st_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
    grp_any[0] |=> irq_st[0])
    else $error("status bit lost event");
  a_irq_level: assert property (@(posedge clk_i) disable iff (rst_i)
    irq_o == |(irq_st & irq_msk))
    else $error("irq level mismatch");

endmodule // ieb_bank

// >>> logic/ieb_gate.sv
// per-source gate: pending flag and enable and nonzero priority
// assumes all inputs already in clk_i domain
`timescale 1ns/1ps
module ieb_gate #(
  parameter int N = 80
) (
  ieb_gate_if.gate g
);
  genvar i;
  // ==========================================================================
  // gating
  generate
    for (i = 0; i < N; i++) begin : g_src
      // flag stays in source; only the request is hidden
      assign g.req[i] = g.pend[i] & g.en[i] & (g.prio != ieb_pkg::PRIO_OFF);
    end
  endgenerate
endmodule // ieb_gate

// >>> logic/ieb_gate_if.sv
// interface carrying pending flags, enables and gated requests
// assumes one clock domain shared by bank and gate
`timescale 1ns/1ps
interface ieb_gate_if #(parameter int N = 80);
  logic [N-1:0] pend;
  logic [N-1:0] en;
  logic [2:0]   prio;
  logic [N-1:0] req;
  modport bank (output pend, output en, output prio, input req);
  modport gate (input pend, input en, input prio, output req);
endinterface

// >>> logic/ieb_pkg.sv
// package for the interrupt enable bank: register map, masks, reset values
// assumes a 32-bit classic wishbone slave port, word aligned registers
package ieb_pkg;

  // ==========================================================================
  // register offsets (byte addresses)
  localparam logic [7:0] OFS_EN1     = 8'h00;
  localparam logic [7:0] OFS_EN2     = 8'h04;
  localparam logic [7:0] OFS_EN3     = 8'h08;
  localparam logic [7:0] OFS_EN4     = 8'h0C;
  localparam logic [7:0] OFS_EN5     = 8'h10;
  localparam logic [7:0] OFS_PEND    = 8'h14;
  localparam logic [7:0] OFS_IRQ_ST  = 8'h18;
  localparam logic [7:0] OFS_IRQ_MSK = 8'h1C;
  localparam logic [7:0] OFS_PRIO    = 8'h20;

  // ==========================================================================
  // implemented-bit masks, one per enable register
  localparam int          NUM_EN = 5;
  localparam logic [15:0] MASK_EN1 = 16'h0007;
  localparam logic [15:0] MASK_EN2 = 16'h3FE3;
  localparam logic [15:0] MASK_EN3 = 16'h4066;
  localparam logic [15:0] MASK_EN4 = 16'h210E;
  localparam logic [15:0] MASK_EN5 = 16'h3FBE;
  localparam logic [79:0] MASK_ALL = {MASK_EN5, MASK_EN4, MASK_EN3, MASK_EN2, MASK_EN1};

  // ==========================================================================
  // reset values and priority codes
  localparam logic [15:0] RST_EN      = 16'h0000;
  localparam logic [2:0]  RST_PRIO    = 3'h4;
  localparam logic [2:0]  PRIO_OFF    = 3'h0;
  localparam logic [2:0]  PRIO_MAX    = 3'h7;
  localparam logic [4:0]  RST_IRQ     = 5'h00;

endpackage

// >>> verif/ieb_src_model.sv
// source model: sticky pending flags raised by event pulses
// assumes the bank's clk_i; the bench services flags with clr_i
`timescale 1ns/1ps
module ieb_src_model (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // events and service
  input  wire logic [79:0] fire_i,
  input  wire logic        clr_i,
  // flags toward the bank
  output logic      [79:0] pend_o
);
  // flag stays until serviced, whatever the enables do
  always_ff @(posedge clk_i) begin
    if (rst_i || clr_i) pend_o <= 80'h0;
    else pend_o <= pend_o | fire_i;
  end
endmodule // ieb_src_model

// >>> verif/interrupt_enable_bank_tb_top.sv
// bench for the enable bank: wishbone master, random enables and events
// assumes one answer per access, ack_o or err_o, within 20 cycles
`timescale 1ns/1ps
module interrupt_enable_bank_tb_top;
  // ====================
  // signals
  logic        clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
  logic [7:0]  adr_i = 8'h00;
  logic [31:0] dat_i = 32'h0, dat_o, rd;
  logic        ack_o, err_o, irq_o, e, clr = 1'b0;
  logic [79:0] fire = 80'h0, en = 80'h0, pend, req_o;
  logic [2:0]  prio_o, pr = ieb_pkg::RST_PRIO;
  logic [3:0]  sel = 4'h0;
  int          n_errors = 0, compares = 0, seed = 32'h62E8;

  always #2 clk_i = ~clk_i;

  ieb_bank ieb_bank_inst (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel), .dat_i(dat_i), .dat_o(dat_o),
    .ack_o(ack_o), .err_o(err_o), .pend_i(pend), .req_o(req_o), .prio_o(prio_o),
    .irq_o(irq_o));
  ieb_src_model ieb_src_model_inst (.clk_i(clk_i), .rst_i(rst_i), .fire_i(fire),
    .clr_i(clr), .pend_o(pend));

  // ====================
  // expectations and tasks
  function automatic logic [79:0] exp_req(input logic [2:0] p);
    return (p == 3'h0) ? 80'h0 : pend & en & ieb_pkg::MASK_ALL;
  endfunction
  function automatic logic [31:0] exp_st(input logic [79:0] r);
    logic [31:0] s;
    s = 32'h0;
    for (int k = 0; k < 5; k++) s[k] = |r[16*k +: 16];
    return s;
  endfunction
  task automatic stop_test;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [79:0] ex, input logic [79:0] got);
    compares++;
    if (got !== ex) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, ex, got);
    end
  endtask
  // request held until ack or err is sampled high at an edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk_i);
    {cyc_i, stb_i, we_i, adr_i, dat_i, sel} <= {2'b11, w, a, d, 4'hF};
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (!(ack_o === 1'b1 || err_o === 1'b1) && k < 20);
    if (!(ack_o === 1'b1 || err_o === 1'b1)) begin
      n_errors++;
      stop_test();
    end
    rd = dat_o;
    e = err_o;
    {cyc_i, stb_i, we_i, sel} <= 7'h00;
  endtask
  task automatic gate(input int i);
    logic [15:0] d;
    d = 16'($random(seed));
    wb(1'b1, 8'(4 * i), {16'h0, d});
    en[16*i +: 16] = d;
    // external inputs count as routed to a remappable pin
    fire <= 80'({$random(seed), $random(seed), $random(seed)});
    @(posedge clk_i);
    fire <= 80'h0;
    repeat (3) @(posedge clk_i);
    chk("gated request", exp_req(pr), req_o);
  endtask

  initial begin : main
    int i;
    int j;
    logic [15:0] d;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    for (i = 0; i < 5; i++) begin
      wb(1'b0, 8'(4 * i), 32'h0);
      chk("enable at reset", 80'h0, 80'(rd));
    end
    // all-ones first: unimplemented bits must drop it
    for (j = 0; j < 8; j++) begin
      for (i = 0; i < 5; i++) begin
        d = (j == 0) ? 16'hFFFF : 16'($random(seed));
        wb(1'b1, 8'(4 * i), {16'h0, d});
        en[16*i +: 16] = d;
        wb(1'b0, 8'(4 * i), 32'h0);
        chk("readback", 80'(d) & (ieb_pkg::MASK_ALL >> (16 * i)), 80'(rd));
      end
    end
    gate(0);
    gate(1);
    gate(2);
    gate(3);
    gate(4);
    gate(4);
    for (i = 0; i < 5; i++) wb(1'b1, 8'(4 * i), 32'h0);
    en = 80'h0;
    repeat (3) @(posedge clk_i);
    chk("blocked request", 80'h0, req_o);
    for (i = 0; i < 5; i++) wb(1'b1, 8'(4 * i), 32'hFFFF);
    en = {80{1'b1}};
    repeat (3) @(posedge clk_i);
    chk("flag kept", exp_req(pr), req_o);
    for (j = 0; j < 2; j++) begin
      pr = (j == 0) ? ieb_pkg::PRIO_OFF : ieb_pkg::PRIO_MAX;
      wb(1'b1, ieb_pkg::OFS_PRIO, {29'h0, pr});
      repeat (3) @(posedge clk_i);
      chk("priority code", 80'(pr), 80'(prio_o));
      chk("priority gating", exp_req(pr), req_o);
    end
    wb(1'b1, ieb_pkg::OFS_IRQ_MSK, 32'h1F);
    wb(1'b0, ieb_pkg::OFS_IRQ_ST, 32'h0);
    wb(1'b0, ieb_pkg::OFS_IRQ_ST, 32'h0);
    chk("status", 80'(exp_st(exp_req(pr))), 80'(rd));
    chk("irq raised", 80'(exp_st(exp_req(pr)) != 0), 80'(irq_o));
    wb(1'b1, ieb_pkg::OFS_IRQ_MSK, 32'h0);
    chk("irq masked", 80'h0, 80'(irq_o));
    clr <= 1'b1;
    @(posedge clk_i);
    clr <= 1'b0;
    repeat (3) @(posedge clk_i);
    wb(1'b0, ieb_pkg::OFS_IRQ_ST, 32'h0);
    wb(1'b1, ieb_pkg::OFS_IRQ_MSK, 32'h1F);
    chk("irq cleared", 80'h0, 80'(irq_o));
    // second reset in mid-run
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    en = 80'h0;
    pr = ieb_pkg::RST_PRIO;
    wb(1'b0, ieb_pkg::OFS_EN3, 32'h0);
    chk("enable after reset", 80'h0, 80'(rd));
    chk("priority after reset", 80'(ieb_pkg::RST_PRIO), 80'(prio_o));
    wb(1'b0, 8'h40, 32'h0);
    chk("unmapped", 80'h1, 80'(e));
    stop_test();
  end
endmodule // interrupt_enable_bank_tb_top
